// file: src/sac_pkg.sv
// Package: register map, field layout, reset values and timing counts
package sac_pkg;

    // Register byte addresses on the CPU memory bus
    localparam logic [15:0] SAC_ADDR_RESULT_LO = 16'hFF08;
    localparam logic [15:0] SAC_ADDR_RESULT_HI = 16'hFF09;
    localparam logic [15:0] SAC_ADDR_MODE = 16'hFF28;
    localparam logic [15:0] SAC_ADDR_CHANNEL = 16'hFF29;
    localparam logic [15:0] SAC_ADDR_PFMODE = 16'hFF2A;
    localparam logic [15:0] SAC_ADDR_THRESH = 16'hFF2B;

    // Values after reset
    localparam logic [7:0] SAC_MODE_RESET = 8'h00;
    localparam logic [7:0] SAC_CHANNEL_RESET = 8'h00;
    localparam logic [7:0] SAC_PFMODE_RESET = 8'h00;
    localparam logic [7:0] SAC_THRESH_RESET = 8'h00;

    // Writable bits per register; the rest read as zero
    localparam logic [7:0] SAC_MODE_WMASK = 8'hB9;
    localparam logic [7:0] SAC_CHANNEL_WMASK = 8'h07;
    localparam logic [7:0] SAC_PFMODE_WMASK = 8'hC0;

    // Field positions
    localparam int SAC_MODE_ENABLE_BIT = 7;
    localparam int SAC_MODE_REFGEN_BIT = 0;
    localparam int SAC_MODE_FR_LSB = 3;
    localparam int SAC_PF_ENABLE_BIT = 7;
    localparam int SAC_PF_POLARITY_BIT = 6;
    localparam int SAC_RESULT_SHIFT = 6;

    // Approximation width and first trial value
    localparam int SAC_RES_BITS = 10;
    localparam logic [9:0] SAC_APPROX_FIRST = 10'h200;
    localparam logic [3:0] SAC_MSB_INDEX = 4'h9;

    // Cycles per bit decision for each conversion-time code except the prohibited codes 3 and 7
    localparam logic [7:0] SAC_BITCYC_FR0 = 8'h0C;
    localparam logic [7:0] SAC_BITCYC_FR1 = 8'h0A;
    localparam logic [7:0] SAC_BITCYC_FR2 = 8'h08;
    localparam logic [7:0] SAC_BITCYC_FR4 = 8'h06;
    localparam logic [7:0] SAC_BITCYC_FR5 = 8'h05;
    localparam logic [7:0] SAC_BITCYC_FR6 = 8'h04;
    // Sampling lasts this many bit periods
    localparam int SAC_SAMPLE_PERIODS = 2;

    typedef enum logic [1:0] {
        SAC_IDLE,
        SAC_SAMPLE,
        SAC_CONVERT
    } sac_state_e;

    // One access on the CPU memory bus
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sac_bus_req_s;

endpackage

// file: src/sac_sar_engine.sv
// Sample, hold and bit-by-bit approximation sequencer
`timescale 1ns/10ps
module sac_sar_engine
    import sac_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic comp_i,
    input wire logic [7:0] bit_cyc_i,
    output logic sample_o,
    output logic [9:0] tap_o,
    output logic [9:0] result_o,
    output logic done_o
);

    sac_state_e state_reg;
    logic [8:0] cnt_reg;
    logic [3:0] bit_idx_reg;

    wire logic [8:0] sample_len = 9'(bit_cyc_i * SAC_SAMPLE_PERIODS) - 9'h001;
    wire logic [8:0] bit_len = {1'b0, bit_cyc_i} - 9'h001;
    wire logic last_bit = (bit_idx_reg == 4'h0);
    wire logic [3:0] next_idx = bit_idx_reg - 4'h1;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= SAC_IDLE;
            cnt_reg <= 9'h000;
            bit_idx_reg <= 4'h0;
            tap_o <= 10'h000;
            result_o <= 10'h000;
            sample_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (!run_i) begin
                // Stop at once; the partial value is dropped
                state_reg <= SAC_IDLE;
                sample_o <= 1'b0;
            end else if (restart_i || state_reg == SAC_IDLE) begin
                state_reg <= SAC_SAMPLE;
                cnt_reg <= sample_len;
                sample_o <= 1'b1;
            end else if (cnt_reg != 9'h000) begin
                cnt_reg <= cnt_reg - 9'h001;
            end else if (state_reg == SAC_SAMPLE) begin
                // Hold from here until the last decision
                sample_o <= 1'b0;
                state_reg <= SAC_CONVERT;
                tap_o <= SAC_APPROX_FIRST;
                bit_idx_reg <= SAC_MSB_INDEX;
                cnt_reg <= bit_len;
            end else begin
                tap_o[bit_idx_reg] <= comp_i;
                if (last_bit) begin
                    result_o <= {tap_o[9:1], comp_i};
                    done_o <= 1'b1;
                    state_reg <= SAC_SAMPLE;
                    cnt_reg <= sample_len;
                    sample_o <= 1'b1;
                end else begin
                    tap_o[next_idx] <= 1'b1;
                    bit_idx_reg <= next_idx;
                    cnt_reg <= bit_len;
                end
            end
        end
    end

endmodule

// file: src/sac_adc_control.sv
// Converter control: registers, bus slave, sequencing and compare gate
`timescale 1ns/10ps
module sac_adc_control
    import sac_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire sac_bus_req_s bus_req_i,
    input wire logic comp_i,
    output logic [15:0] bus_rdata_o,
    output logic bus_wait_o,
    output logic [2:0] channel_sel_o,
    output logic sample_o,
    output logic [9:0] tap_o,
    output logic refgen_enable_o,
    output logic conversion_done_irq_o
);

    // Reset release
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // Registers
    logic [7:0] converter_mode_control_reg;
    logic [7:0] channel_select_reg;
    logic [7:0] powerfail_mode_reg;
    logic [7:0] powerfail_threshold_reg;
    logic [15:0] conversion_result_reg;

    // Cycles per bit decision for a conversion-time code
    function automatic logic [7:0] bit_cycles(input logic [2:0] code);
        logic [7:0] c;
        c = SAC_BITCYC_FR0;
        unique case (code)
            3'h0: c = SAC_BITCYC_FR0;
            3'h1: c = SAC_BITCYC_FR1;
            3'h2: c = SAC_BITCYC_FR2;
            3'h4: c = SAC_BITCYC_FR4;
            3'h5: c = SAC_BITCYC_FR5;
            3'h6: c = SAC_BITCYC_FR6;
            // Prohibited codes fall back to the slowest timing
            default: c = SAC_BITCYC_FR0;
        endcase
        return c;
    endfunction

    // Interrupt gate on the upper eight result bits
    function automatic logic pf_pass(
        input logic enable,
        input logic polarity,
        input logic [7:0] upper,
        input logic [7:0] threshold
    );
        logic at_or_above;
        at_or_above = (upper >= threshold);
        if (!enable) begin
            return 1'b1;
        end
        return polarity ? !at_or_above : at_or_above;
    endfunction

    // Address decode
    wire logic hit_lo = (bus_req_i.addr == SAC_ADDR_RESULT_LO);
    wire logic hit_hi = (bus_req_i.addr == SAC_ADDR_RESULT_HI);
    wire logic hit_mode = (bus_req_i.addr == SAC_ADDR_MODE);
    wire logic hit_chan = (bus_req_i.addr == SAC_ADDR_CHANNEL);
    wire logic hit_pfm = (bus_req_i.addr == SAC_ADDR_PFMODE);
    wire logic hit_pft = (bus_req_i.addr == SAC_ADDR_THRESH);

    wire logic wr_mode = bus_req_i.wr && hit_mode;
    wire logic wr_chan = bus_req_i.wr && hit_chan;
    wire logic wr_pfm = bus_req_i.wr && hit_pfm;
    wire logic wr_pft = bus_req_i.wr && hit_pft;
    wire logic wr_any = wr_mode || wr_chan || wr_pfm || wr_pft;
    wire logic rd_result = bus_req_i.rd && (hit_lo || hit_hi);

    // Read mux; fixed-zero bits come back as stored zeros
    wire logic [15:0] rd_mux =
        hit_lo ? conversion_result_reg :
        hit_hi ? {8'h00, conversion_result_reg[15:8]} :
        hit_mode ? {8'h00, converter_mode_control_reg} :
        hit_chan ? {8'h00, channel_select_reg} :
        hit_pfm ? {8'h00, powerfail_mode_reg} :
        hit_pft ? {8'h00, powerfail_threshold_reg} :
        16'h0000;

    wire logic conv_enable =
        converter_mode_control_reg[SAC_MODE_ENABLE_BIT];
    wire logic pf_enable = powerfail_mode_reg[SAC_PF_ENABLE_BIT];
    wire logic pf_polarity = powerfail_mode_reg[SAC_PF_POLARITY_BIT];
    wire logic [2:0] fr_code =
        converter_mode_control_reg[SAC_MODE_FR_LSB +: 3];
    wire logic [7:0] bit_cyc = bit_cycles(fr_code);

    wire logic eng_done;
    wire logic [9:0] eng_result;
    wire logic eng_sample;
    wire logic [9:0] eng_tap;

    // Write path
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            converter_mode_control_reg <= SAC_MODE_RESET;
            channel_select_reg <= SAC_CHANNEL_RESET;
            powerfail_mode_reg <= SAC_PFMODE_RESET;
            powerfail_threshold_reg <= SAC_THRESH_RESET;
        end else begin
            if (wr_mode) begin
                converter_mode_control_reg <=
                    bus_req_i.wdata & SAC_MODE_WMASK;
            end
            if (wr_chan) begin
                // Upper five bits forced to zero
                channel_select_reg <=
                    bus_req_i.wdata & SAC_CHANNEL_WMASK;
            end
            if (wr_pfm) begin
                powerfail_mode_reg <=
                    bus_req_i.wdata & SAC_PFMODE_WMASK;
            end
            if (wr_pft) begin
                powerfail_threshold_reg <= bus_req_i.wdata;
            end
        end
    end

    // Bus answer: one wait cycle on result reads and register writes, data stands until next read
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bus_wait_o <= 1'b0;
            bus_rdata_o <= 16'h0000;
        end else begin
            bus_wait_o <= rd_result || wr_any;
            if (bus_req_i.rd) begin
                bus_rdata_o <= rd_mux;
            end
        end
    end

    // Result has no reset: its content is undefined after reset
    always_ff @(posedge clk_i) begin
        if (eng_done) begin
            conversion_result_reg <=
                {eng_result, 6'h00};
        end
    end

    // Analog-facing outputs and interrupt
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            channel_sel_o <= 3'h0;
            refgen_enable_o <= 1'b0;
            conversion_done_irq_o <= 1'b0;
            sample_o <= 1'b0;
            tap_o <= 10'h000;
        end else begin
            channel_sel_o <= channel_select_reg[2:0];
            refgen_enable_o <=
                converter_mode_control_reg[SAC_MODE_REFGEN_BIT];
            sample_o <= eng_sample;
            tap_o <= eng_tap;
            // Decided on the fresh result, same cycle it is latched
            conversion_done_irq_o <= eng_done &&
                pf_pass(pf_enable, pf_polarity, eng_result[9:2],
                        powerfail_threshold_reg);
        end
    end

    // Any register write restarts the sequence from sampling while the enable bit is set
    sac_sar_engine u_engine (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .run_i(conv_enable),
        .restart_i(wr_any),
        .comp_i(comp_i),
        .bit_cyc_i(bit_cyc),
        .sample_o(eng_sample),
        .tap_o(eng_tap),
        .result_o(eng_result),
        .done_o(eng_done)
    );

endmodule

// file: tb/sac_adc_control_chk.sv
// Port-level checker for the converter control block
`timescale 1ns/10ps
module sac_adc_control_chk
    import sac_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire sac_bus_req_s bus_req_i,
    input wire logic comp_i,
    input wire logic [15:0] bus_rdata_o,
    input wire logic bus_wait_o,
    input wire logic [2:0] channel_sel_o,
    input wire logic sample_o,
    input wire logic [9:0] tap_o,
    input wire logic refgen_enable_o,
    input wire logic conversion_done_irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    wire logic [15:0] ad = bus_req_i.addr;
    wire logic rd = bus_req_i.rd;
    wire logic wr = bus_req_i.wr;
    wire logic regw = wr && ad >= SAC_ADDR_MODE && ad <= SAC_ADDR_THRESH;
    logic en_reg;
    // Mirror of the enable bit, only to qualify the restart and first-tap checks and the enabled-write cover
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            en_reg <= 1'b0;
        end else if (wr && ad == SAC_ADDR_MODE) begin
            en_reg <= bus_req_i.wdata[7];
        end
    end
    property p_wait_wr;
        regw |=> bus_wait_o;
    endproperty
    a_wait_wr: assert property (p_wait_wr) else $error("no wait cycle");
    property p_res_lo;
        rd && ad == SAC_ADDR_RESULT_LO |=> bus_wait_o && !(|bus_rdata_o[5:0]);
    endproperty
    a_res_lo: assert property (p_res_lo) else $error("bad word read");
    property p_res_hi;
        rd && ad == SAC_ADDR_RESULT_HI |=> bus_wait_o && !(|bus_rdata_o[15:8]);
    endproperty
    a_res_hi: assert property (p_res_hi) else $error("bad byte read");
    property p_chan_rd;
        rd && ad == SAC_ADDR_CHANNEL |=> !bus_wait_o && !(|bus_rdata_o[15:3]);
    endproperty
    a_chan_rd: assert property (p_chan_rd) else $error("channel bits");
    property p_pf_rd;
        rd && ad == SAC_ADDR_PFMODE
            |=> !(|bus_rdata_o[15:8]) && !(|bus_rdata_o[5:0]);
    endproperty
    a_pf_rd: assert property (p_pf_rd) else $error("pf mode bits");
    property p_chan;
        wr && ad == SAC_ADDR_CHANNEL
            |-> ##2 channel_sel_o == $past(bus_req_i.wdata[2:0], 2);
    endproperty
    a_chan: assert property (p_chan) else $error("channel select");
    property p_refgen;
        wr && ad == SAC_ADDR_MODE
            |-> ##2 refgen_enable_o == $past(bus_req_i.wdata[0], 2);
    endproperty
    a_refgen: assert property (p_refgen) else $error("refgen mirror");
    property p_stop;
        wr && ad == SAC_ADDR_MODE && !bus_req_i.wdata[7]
            |-> ##3 (!sample_o && !conversion_done_irq_o) [*2];
    endproperty
    a_stop: assert property (p_stop) else $error("no stop");
    property p_restart;
        regw && en_reg && ad != SAC_ADDR_MODE |-> ##[1:5] sample_o;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");
    property p_first_tap;
        $fell(sample_o) && $past(en_reg) && en_reg
            |-> tap_o == SAC_APPROX_FIRST;
    endproperty
    a_first_tap: assert property (p_first_tap) else $error("first tap");
    cover property (conversion_done_irq_o);
    cover property (regw && en_reg);
    cover property ($fell(sample_o));
endmodule

bind sac_adc_control sac_adc_control_chk i_chk (.clk_i, .resetn_i,
    .bus_req_i, .comp_i, .bus_rdata_o, .bus_wait_o, .channel_sel_o,
    .sample_o, .tap_o, .refgen_enable_o, .conversion_done_irq_o);

// file: tb/sac_analog_model.sv
// Behavioural analog front end: selector, sample/hold, comparator
`timescale 1ns/10ps
module sac_analog_model (
    input wire logic clk_i,
    input wire logic sample_i,
    input wire logic [2:0] channel_i,
    input wire logic [7:0][9:0] level_i,
    input wire logic [9:0] tap_i,
    output logic comp_o
);
    logic [9:0] held_reg;
    // No reset: held value is unknown until the first sample
    always_ff @(posedge clk_i) begin
        if (sample_i) begin
            held_reg <= level_i[channel_i];
        end
    end
    assign comp_o = held_reg >= tap_i;
endmodule

// file: tb/sac_adc_control_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module sac_adc_control_tb
    import sac_pkg::*;
;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    sac_bus_req_s req = '0;
    logic comp, bus_wait, sample, refgen, irq;
    logic [15:0] rdata;
    logic [2:0] chan;
    logic [9:0] tap;
    logic [7:0][9:0] lvl;
    logic [2:0] frs [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    logic [15:0] raddr [5] = '{SAC_ADDR_MODE, SAC_ADDR_CHANNEL,
        SAC_ADDR_PFMODE, SAC_ADDR_THRESH, 16'hFF30};
    logic [7:0] up;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int got;
    always #12.5 clk_i = ~clk_i;
    sac_adc_control i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .bus_req_i(req), .comp_i(comp), .bus_rdata_o(rdata),
        .bus_wait_o(bus_wait), .channel_sel_o(chan), .sample_o(sample),
        .tap_o(tap), .refgen_enable_o(refgen),
        .conversion_done_irq_o(irq));
    sac_analog_model i_ana (.clk_i(clk_i), .sample_i(sample),
        .channel_i(chan), .level_i(lvl), .tap_i(tap), .comp_o(comp));
    function automatic logic irq_exp(input logic pol, input logic [7:0] u,
            input logic [7:0] thr);
        return pol ? (u < thr) : (u >= thr);
    endfunction
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a,
            input logic [7:0] d);
        @(posedge clk_i);
        #2;
        req = '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge clk_i);
        #2;
        req.wr = 1'b0;
        req.rd = 1'b0;
    endtask
    task automatic count_irq(input int n, output int c);
        c = 0;
        repeat (3) @(posedge clk_i);
        repeat (n) begin
            @(posedge clk_i);
            #1;
            if (irq === 1'b1) c++;
        end
    endtask
    task automatic wait_irq(input int n);
        int k;
        k = 0;
        repeat (3) @(posedge clk_i);
        while (n > 0 && k < 800) begin
            @(posedge clk_i);
            #1;
            k++;
            if (irq === 1'b1) n--;
        end
        check(16'(n), 16'h0000);
    endtask
    // Ceiling is about five times the expected run length
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(16379));
        for (int i = 0; i < 8; i++) lvl[i] = 10'($urandom_range(4, 1019));
        lvl[0] = 10'h000;
        lvl[7] = 10'h3FF;
        repeat (3) @(posedge clk_i);
        #2;
        resetn_i = 1'b1;
        repeat (3) @(posedge clk_i);
        foreach (raddr[i]) begin
            acc(1'b0, raddr[i], 8'h00);
            check(rdata, 16'h0000);
        end
        acc(1'b1, SAC_ADDR_CHANNEL, 8'h05);
        acc(1'b0, SAC_ADDR_CHANNEL, 8'h00);
        check(rdata, 16'h0005);
        acc(1'b1, SAC_ADDR_PFMODE, 8'hFF);
        acc(1'b0, SAC_ADDR_PFMODE, 8'h00);
        check(rdata, 16'h00C0);
        acc(1'b1, 16'hFF30, 8'hFF);
        acc(1'b0, 16'hFF30, 8'h00);
        check(rdata, 16'h0000);
        acc(1'b1, SAC_ADDR_PFMODE, 8'h00);
        $display("register test done");
        acc(1'b1, SAC_ADDR_MODE, 8'h01);
        repeat (570) @(posedge clk_i);
        for (int ch = 0; ch < 8; ch++) begin
            acc(1'b1, SAC_ADDR_MODE, 8'h01);
            acc(1'b1, SAC_ADDR_MODE, 8'h81 | (8'(frs[ch % 6]) << 3));
            acc(1'b1, SAC_ADDR_CHANNEL, 8'(ch));
            wait_irq(2);
            acc(1'b0, SAC_ADDR_RESULT_LO, 8'h00);
            check(rdata, {lvl[ch], 6'h00});
            acc(1'b0, SAC_ADDR_RESULT_HI, 8'h00);
            check(rdata, 16'(lvl[ch][9:2]));
        end
        $display("conversion test done");
        acc(1'b1, SAC_ADDR_CHANNEL, 8'h03);
        up = lvl[3][9:2];
        for (int c = 0; c < 4; c++) begin
            acc(1'b1, SAC_ADDR_PFMODE, {1'b1, c[0], 6'h00});
            acc(1'b1, SAC_ADDR_THRESH, up + 8'(c[1]));
            count_irq(300, got);
            check(16'(got != 0), 16'(irq_exp(c[0], up, up + 8'(c[1]))));
        end
        $display("compare test done");
        acc(1'b1, SAC_ADDR_PFMODE, 8'h00);
        acc(1'b1, SAC_ADDR_MODE, 8'h01);
        count_irq(300, got);
        check(16'(got), 16'h0000);
        check(16'(sample), 16'h0000);
        $display("stop test done");
        complete_run();
    end
endmodule
